// >>> hdl/external_bus_ready_control.sv
// Operation
// - synchronous ready is sampled directly, giving the shortest cycle
// - asynchronous ready adds one extra stage, so at least one waitstate
// - ready high at a sample point adds a waitstate, low ends the cycle
// - programmed length with memory waitstates runs before ready sampling starts
// - multiplexed mode adds trailing waitstate; tristate option adds one more
// - multiplexing waitstate gives one more output clock to withdraw ready
// - a running bus cycle finishes before the bus is granted
// - latched chip select driven high one half clock, then released
`timescale 1ns/1ps
module external_bus_ready_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ready_n_i,
  input wire logic hold_req_n_i,
  output logic system_clock_output_o,
  output bus_ready_pkg::cmd_type bus_cmd_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic cs_n_o,
  output logic cs_oe_o,
  output logic hold_ack_n_o,
  output logic bus_request_output_o
);
  import bus_ready_pkg::*;

  ctrl_type ctrl_q;
  cmd_type cmd_q;
  state_type state_q;
  logic pending_q;
  logic [3:0] cnt_q;
  logic [3:0] waits_q;
  logic phase_q;
  logic rdy_async_n_q;
  logic rdy_sync_n;
  logic hold_sync_n;
  logic rise;
  logic ready_high;
  logic start;
  logic wb_req;
  logic [3:0] trail_len;
  logic [31:0] rd_data;

  sync_two_stage #(
    .WIDTH(2),
    .RESET_VALUE(2'h3)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({ready_n_i, hold_req_n_i}),
    .sync_o({rdy_sync_n, hold_sync_n})
  );

  // output clock runs at half the core rate; one core cycle is one half_clock_unit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      phase_q <= 1'b0;
    else
      phase_q <= ~phase_q;
  end

  // edge where the output clock rises
  assign rise = ~phase_q;

  // extra async stage costs one waitstate
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdy_async_n_q <= 1'b1;
    else if (rise)
      rdy_async_n_q <= rdy_sync_n;
  end

  // sync mode reads the pin stage directly
  assign ready_high = ctrl_q.async_ready ? rdy_async_n_q : rdy_sync_n;

  always_comb
  begin
    trail_len = 4'h0;
    if (ctrl_q.mux_mode)
      trail_len = trail_len + TRAIL_MUX_WAIT;
    if (ctrl_q.tristate_wait_option)
      trail_len = trail_len + TRAIL_TRISTATE_WAIT;
  end

  // a new cycle never starts under a pending hold
  assign start = (state_q == ST_IDLE) && rise && hold_sync_n && pending_q;

  assign wb_req = cyc_i && stb_i && !ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= wb_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= CTRL_RESET;
    else if (wb_req && we_i && adr_i == CTRL_OFFSET)
    begin
      if (sel_i[0])
        ctrl_q[7:0] <= dat_i[7:0];
      if (sel_i[1])
        ctrl_q[CTRL_CS_LATCHED_BIT] <= dat_i[CTRL_CS_LATCHED_BIT];
    end
  end

  // command is taken only while no other one waits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pending_q <= 1'b0;
      cmd_q <= '0;
    end
    else if (wb_req && we_i && adr_i == CMD_OFFSET && !pending_q)
    begin
      pending_q <= 1'b1;
      cmd_q.addr <= dat_i[CMD_ADDR_LSB +: 16];
      cmd_q.write <= dat_i[CMD_WRITE_BIT];
    end
    else if (start)
      pending_q <= 1'b0;
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      CTRL_OFFSET: rd_data[CTRL_WIDTH-1:0] = ctrl_q;
      CMD_OFFSET: rd_data[CMD_WRITE_BIT:0] = cmd_q;
      STATUS_OFFSET:
      begin
        rd_data[STATUS_BUSY_BIT] = (state_q != ST_IDLE) && (state_q != ST_HELD);
        rd_data[STATUS_HELD_BIT] = (state_q == ST_HELD);
        rd_data[STATUS_PENDING_BIT] = pending_q;
        rd_data[STATUS_WAITS_LSB +: 4] = waits_q;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (wb_req && !we_i)
      dat_o <= rd_data;
  end

  // ready-controlled waitstates of the last cycle, saturating
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      waits_q <= 4'h0;
    else if (start)
      waits_q <= 4'h0;
    else if (state_q == ST_WAIT && rise && ready_high && waits_q != 4'hF)
      waits_q <= waits_q + 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      cs_n_o <= 1'b1;
      cs_oe_o <= 1'b1;
      hold_ack_n_o <= 1'b1;
      bus_cmd_o <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (rise && !hold_sync_n)
          begin
            // latched chip select driven high first
            if (ctrl_q.cs_latched)
            begin
              state_q <= ST_CSREL;
              cnt_q <= {1'b0, CS_RELEASE_CYCLES};
            end
            else
            begin
              state_q <= ST_HELD;
              cs_oe_o <= 1'b0;
              hold_ack_n_o <= 1'b0;
            end
          end
          else if (start)
          begin
            state_q <= ST_CMD;
            cnt_q <= ctrl_q.memory_cycle_wait_count;
            bus_cmd_o <= cmd_q;
            cs_n_o <= 1'b0;
            rd_n_o <= cmd_q.write;
            wr_n_o <= ~cmd_q.write;
          end
        end
        ST_CMD:
        begin
          if (rise)
          begin
            if (cnt_q != 4'h0)
              cnt_q <= cnt_q - 4'h1;
            else if (ctrl_q.ready_enable)
              state_q <= ST_WAIT;
            else
            begin
              rd_n_o <= 1'b1;
              wr_n_o <= 1'b1;
              cs_n_o <= 1'b1;
              cnt_q <= trail_len;
              state_q <= (trail_len == 4'h0) ? ST_IDLE : ST_TRAIL;
            end
          end
        end
        ST_WAIT:
        begin
          // low ends the cycle, high waits on
          if (rise && !ready_high)
          begin
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            cs_n_o <= 1'b1;
            cnt_q <= trail_len;
            state_q <= (trail_len == 4'h0) ? ST_IDLE : ST_TRAIL;
          end
        end
        ST_TRAIL:
        begin
          // mux waitstate gives ready time to fall back
          if (rise)
          begin
            if (cnt_q == 4'h1)
              state_q <= ST_IDLE;
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_CSREL:
        begin
          if (cnt_q == 4'h1)
          begin
            cs_oe_o <= 1'b0;
            hold_ack_n_o <= 1'b0;
            state_q <= ST_HELD;
          end
          cnt_q <= cnt_q - 4'h1;
        end
        ST_HELD:
        begin
          if (rise && hold_sync_n)
          begin
            cs_oe_o <= 1'b1;
            hold_ack_n_o <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      system_clock_output_o <= 1'b0;
      bus_request_output_o <= 1'b0;
    end
    else
    begin
      system_clock_output_o <= ~phase_q;
      // a waiting command while held asks for the bus back
      bus_request_output_o <= (state_q == ST_HELD) && pending_q;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_sync_ready_end: assert property (
    !ctrl_q.async_ready && state_q == ST_WAIT && rise && !rdy_sync_n |=> state_q != ST_WAIT
  ) else $error("sync ready low did not end the cycle");

  a_async_stage: assert property (
    ctrl_q.async_ready && rise |=> rdy_async_n_q == $past(rdy_sync_n) ##1 rdy_async_n_q == $past(rdy_async_n_q)
  ) else $error("async ready stage not updated on output clock edge");

  a_wait_extend: assert property (
    state_q == ST_WAIT && rise && ready_high |=> state_q == ST_WAIT && !cs_n_o
  ) else $error("ready high did not extend the cycle");

  a_cmd_length: assert property (
    state_q == ST_IDLE && start && ctrl_q.memory_cycle_wait_count == 4'h3
      |=> (state_q == ST_CMD)[*8] ##1 state_q != ST_CMD
  ) else $error("programmed cycle length not kept");

  a_trail_two: assert property (
    $past(state_q) == ST_WAIT && state_q == ST_TRAIL && ctrl_q.mux_mode && ctrl_q.tristate_wait_option
      |-> (state_q == ST_TRAIL)[*4] ##1 state_q == ST_IDLE
  ) else $error("trailing delay not two output clocks");

  a_demux_no_trail: assert property (
    state_q == ST_WAIT && rise && !ready_high && !ctrl_q.mux_mode && !ctrl_q.tristate_wait_option
      |=> state_q == ST_IDLE && rd_n_o && wr_n_o
  ) else $error("demultiplexed cycle has a trailing delay");

  a_grant_after_cycle: assert property (
    $fell(hold_ack_n_o) |-> cs_n_o && rd_n_o && wr_n_o && $past(state_q) inside {ST_IDLE, ST_CSREL}
  ) else $error("bus granted during a running cycle");

  a_cs_release: assert property (
    state_q == ST_IDLE && rise && !hold_sync_n && ctrl_q.cs_latched
      |=> cs_n_o && cs_oe_o ##1 cs_n_o && !cs_oe_o && !hold_ack_n_o
  ) else $error("latched chip select not driven high for one half clock");

  a_sample_on_rise: assert property (
    $past(state_q) == ST_WAIT && state_q != ST_WAIT |-> $past(rise)
  ) else $error("cycle ended away from an output clock rising edge");

endmodule : external_bus_ready_control

// >>> common/bus_ready_pkg.sv
package bus_ready_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  // one half_clock_unit is half a period of the system clock output
  localparam int unsigned HALF_CLOCK_UNIT_NS = 8;
  localparam int unsigned HALF_CLOCK_UNIT_CYCLES = (HALF_CLOCK_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] CS_RELEASE_CYCLES = 3'(HALF_CLOCK_UNIT_CYCLES);

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  localparam int unsigned CTRL_WAIT_LSB = 0;
  localparam int unsigned CTRL_TRISTATE_BIT = 4;
  localparam int unsigned CTRL_MUX_BIT = 5;
  localparam int unsigned CTRL_ASYNC_BIT = 6;
  localparam int unsigned CTRL_READY_EN_BIT = 7;
  localparam int unsigned CTRL_CS_LATCHED_BIT = 8;
  localparam int unsigned CTRL_WIDTH = 9;
  localparam logic [8:0] CTRL_RESET = 9'h000;

  localparam int unsigned CMD_ADDR_LSB = 0;
  localparam int unsigned CMD_WRITE_BIT = 16;

  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_HELD_BIT = 1;
  localparam int unsigned STATUS_PENDING_BIT = 2;
  localparam int unsigned STATUS_WAITS_LSB = 8;

  // trailing delay in clock output cycles
  localparam logic [3:0] TRAIL_MUX_WAIT = 4'h1;
  localparam logic [3:0] TRAIL_TRISTATE_WAIT = 4'h1;

  typedef struct packed {
    logic cs_latched;
    logic ready_enable;
    logic async_ready;
    logic mux_mode;
    logic tristate_wait_option;
    logic [3:0] memory_cycle_wait_count;
  } ctrl_type;

  typedef struct packed {
    logic write;
    logic [15:0] addr;
  } cmd_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_WAIT,
    ST_TRAIL,
    ST_CSREL,
    ST_HELD
  } state_type;

endpackage : bus_ready_pkg

// >>> hdl/sync_two_stage.sv
`timescale 1ns/1ps
module sync_two_stage #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= RESET_VALUE;
      sync_o <= RESET_VALUE;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : sync_two_stage

// >>> tb/ext_device.sv
`timescale 1ns/1ps
module ext_device (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic cs_n_i,
  input wire logic cs_oe_i,
  input wire logic [3:0] extra_i,
  output logic ready_n_o,
  output logic cs_o
);
  logic [4:0] cnt_q;
  assign cs_o = cs_oe_i ? cs_n_i : 1'b1;
  // clocked ready, withdrawn on strobe rise
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (rd_n_i && wr_n_i))
    begin
      cnt_q <= 5'h00;
      ready_n_o <= 1'b1;
    end
    else if (cnt_q == {extra_i, 1'b0})
      ready_n_o <= 1'b0;
    else
      cnt_q <= cnt_q + 5'h01;
  end
endmodule : ext_device

// >>> tb/external_bus_ready_control_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin num_checks++; if ((g) !== (e)) \
  begin n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module external_bus_ready_control_test;
  import bus_ready_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic hold_req_n_i = 1'b1;
  logic [3:0] extra = 4'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic ready_n;
  logic rd_n_o;
  logic wr_n_o;
  logic cs_n_o;
  logic cs_oe_o;
  logic hold_ack_n_o;
  logic bus_request_output;
  logic clk_out;
  logic cs_w;
  logic prev_cs;
  cmd_type bus_cmd_o;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] q;
  int a;
  int b;
  int c;
  wire logic strobe = rd_n_o & wr_n_o;

  always #4 clk_i = ~clk_i;
  // ceiling well above the full sequence
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  external_bus_ready_control dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ready_n_i(ready_n), .hold_req_n_i(hold_req_n_i), .system_clock_output_o(clk_out),
    .bus_cmd_o(bus_cmd_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .cs_n_o(cs_n_o),
    .cs_oe_o(cs_oe_o), .hold_ack_n_o(hold_ack_n_o), .bus_request_output_o(bus_request_output));
  ext_device dev (.clk_i(clk_i), .rst_i(rst_i), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .cs_n_i(cs_n_o),
    .cs_oe_i(cs_oe_o), .extra_i(extra), .ready_n_o(ready_n), .cs_o(cs_w));

  task give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task wait_strobe(input logic lvl);
    int k;
    k = 0;
    while (strobe !== lvl && k < 200)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask : wait_strobe

  task meas(input logic [8:0] cv, output int len);
    wb(1'b1, CTRL_OFFSET, 32'(cv));
    wb(1'b1, CMD_OFFSET, 32'h1_0010);
    wait_strobe(1'b0);
    // strobe launched where the output clock rose
    `CHK("strobe on clock rise", 1'b1, clk_out)
    len = 0;
    while (strobe !== 1'b1 && len < 200)
    begin
      @(posedge clk_i);
      len++;
    end
  endtask : meas

  task gap(input logic [8:0] cv, output int g);
    extra <= 4'h4;
    wb(1'b1, CTRL_OFFSET, 32'(cv));
    wb(1'b1, CMD_OFFSET, 32'h1_0001);
    wait_strobe(1'b0);
    wb(1'b1, CMD_OFFSET, 32'h0_0002);
    wait_strobe(1'b1);
    g = 0;
    while (strobe === 1'b1 && g < 200)
    begin
      @(posedge clk_i);
      g++;
    end
    wait_strobe(1'b1);
    extra <= 4'h0;
  endtask : gap

  task t_regs;
    wb(1'b0, CTRL_OFFSET, 32'h0);
    `CHK("ctrl reset", 32'(CTRL_RESET), q)
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 32'h0, q)
    `CHK("idle grant", 1'b1, hold_ack_n_o)
  endtask : t_regs

  task t_timing;
    meas(9'h000, a);
    meas(9'h003, b);
    `CHK("wait count", 6, b - a)
    extra <= 4'h0;
    meas(9'h080, a);
    `CHK("bus cmd", 17'h1_0010, bus_cmd_o)
    wb(1'b0, CMD_OFFSET, 32'h0);
    `CHK("cmd readback", 32'h0001_0010, q)
    extra <= 4'h3;
    meas(9'h080, b);
    `CHK("ready wait", 6, b - a)
    // three high samples before ready is seen low
    wb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK("status waits", 32'h0000_0300, q)
    extra <= 4'h0;
    meas(9'h0C0, c);
    `CHK("async extra", 2, c - a)
    wb(1'b0, CTRL_OFFSET, 32'h0);
    `CHK("ctrl readback", 32'h0000_00C0, q)
  endtask : t_timing

  task t_trail;
    gap(9'h080, a);
    gap(9'h0A0, b);
    gap(9'h0B0, c);
    `CHK("mux trail", 2, b - a)
    `CHK("tristate trail", 4, c - a)
    gap(9'h090, b);
    `CHK("tristate only", 2, b - a)
  endtask : t_trail

  task t_hold;
    int k;
    extra <= 4'h5;
    wb(1'b1, CTRL_OFFSET, 32'h180);
    wb(1'b1, CMD_OFFSET, 32'h1_0003);
    wait_strobe(1'b0);
    hold_req_n_i <= 1'b0;
    k = 0;
    // grant must not cut the running cycle
    while (strobe !== 1'b1 && k < 200)
    begin
      @(posedge clk_i);
      k++;
      `CHK("early grant", 1'b1, hold_ack_n_o)
    end
    k = 0;
    while (cs_oe_o !== 1'b0 && k < 200)
    begin
      prev_cs = cs_n_o;
      @(posedge clk_i);
      k++;
    end
    `CHK("cs before off", 1'b1, prev_cs)
    `CHK("cs pulled up", 1'b1, cs_w)
    `CHK("granted", 1'b0, hold_ack_n_o)
    wb(1'b1, CMD_OFFSET, 32'h0_0004);
    repeat (4) @(posedge clk_i);
    `CHK("bus request", 1'b1, bus_request_output)
    `CHK("no strobe held", 1'b1, strobe)
    hold_req_n_i <= 1'b1;
    wait_strobe(1'b0);
    `CHK("regained", 1'b1, hold_ack_n_o)
    wait_strobe(1'b1);
    extra <= 4'h0;
  endtask : t_hold

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_timing();
    t_trail();
    t_hold();
    give_verdict();
  end
endmodule : external_bus_ready_control_test
